// ### scl_regs.svh
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH

// ****************************************
// register addresses
// ****************************************
`define SCL_ADDR_STATUS 4'h0
`define SCL_ADDR_CHECKSUM 4'h7
`define SCL_ADDR_SET0 4'h8
`define SCL_ADDR_SET1 4'h9
`define SCL_ADDR_SET2 4'hA
`define SCL_ADDR_SET3 4'hB
`define SCL_ADDR_MAP_CLEAR 4'hC
`define SCL_ADDR_COMMAND 4'hD
`define SCL_ADDR_WP_KEY 4'hE
`define SCL_ADDR_SET7 4'hF

// ****************************************
// key values and reset values
// ****************************************
`define SCL_KEY_UNLOCK 8'h95
`define SCL_KEY_LOCK 8'h31
`define SCL_KEY_MAP_CLEAR 8'hA6
`define SCL_SET_RESET 8'h00

// ****************************************
// field positions
// ****************************************
`define SCL_BIT_CRC_EN 3
`define SCL_BIT_FORCE_FAULT 7
`define SCL_BIT_CMD_CLR_CRC 0
`define SCL_BIT_CMD_CLR_POR 1
`define SCL_BIT_ST_POR 0
`define SCL_BIT_ST_CRC_ERR 1
`define SCL_BIT_ST_WP 2

// ****************************************
// crc constants
// ****************************************
`define SCL_CRC_POLY_LOW 4'h3
`define SCL_CRC_INIT 4'h0
`define SCL_CRC_MSG_W 40

`endif

// ### scl_pkg.sv
package scl_pkg;

  // ****************************************
  // pin group crossing into the clock domain
  // ****************************************
  typedef struct packed {
    logic sclk;
    logic latch;
    logic serial_in;
    logic rst;
    logic oe_n;
  } scl_pins_t;

  // ****************************************
  // one 16-bit frame, msb first
  // ****************************************
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
    logic [3:0] crc;
  } scl_frame_t;

endpackage : scl_pkg

// ### scl_serial_ctrl.sv
// Operation
// RQ1 - reset pin high clears map, holds reset, floats serial_out
// RQ2 - power-up sets the power-up flag to 1
// RQ3 - outputs_allow_low high disables drivers, registers untouched
// RQ4 - latch low: shift serial_in on sclk rise, drive leaving bit
// RQ5 - latch rise decodes frame, checking crc first when enabled
// RQ6 - link crc enable is 0 after power-up or device reset
// RQ7 - host reads by writing address, then clocking with latch high
// RQ8 - read: addressed content leaves on each sclk fall
// RQ9 - frame is 16 bits msb first: addr, data, crc
// RQ10 - write lock is off after power-up
// RQ11 - key 0x95 at Eh unlocks the map
// RQ12 - key 0x31 at Eh locks the map
// RQ13 - write protect status is 1 when locked, else 0
// RQ14 - key 0xA6 at Ch returns all registers to defaults
// RQ15 - map clear leaves the power-up flag alone
// RQ16 - crc check off: no errors, every frame acted on
// RQ17 - crc check on: bad frame discarded, nothing changes
// RQ18 - link crc mismatch never pulls fault alarm low
// RQ19 - mismatch sets error flag until clear command
// RQ20 - checksum over 8h, 9h, Ah, Bh, Fh kept readable
// RQ21 - host may compare checksum instead of reading back each
// RQ22 - both crcs use polynomial x^4 + x + 1
// RQ23 - crc starts at zero, four zeros appended, msb first
// RQ24 - link crc covers the 12 address and data bits
// RQ25 - locked: ordinary writes ignored, key register still works
`timescale 1ns/1ps
`default_nettype none
`include "scl_regs.svh"

module scl_serial_ctrl (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic RESET_I,
  input wire logic SCLK_I,
  input wire logic LATCH_I,
  input wire logic SERIAL_IN_I,
  input wire logic OUTPUTS_ALLOW_LOW_I,
  output logic SERIAL_OUT_O,
  output logic SERIAL_OUT_OE_O,
  output logic FAULT_ALARM_N_O,
  output logic FAULT_ALARM_N_OE_O,
  output logic [7:0] CHANNEL_ON_O
);

  // ****************************************
  // crc helpers
  // ****************************************
  // leading zeros leave a zero-start crc unchanged, so one width serves both
  function automatic logic [3:0] crc4(input logic [`SCL_CRC_MSG_W-1:0] msg);
    logic [3:0] c;
    logic fb;
    c = `SCL_CRC_INIT; // RQ23
    for (int i = `SCL_CRC_MSG_W + 3; i >= 0; i--) begin
      fb = c[3];
      c = {c[2:0], (i >= 4) ? msg[i-4] : 1'b0}; // RQ23
      if (fb) begin
        c = c ^ `SCL_CRC_POLY_LOW; // RQ22
      end
    end
    return c;
  endfunction : crc4

  function automatic logic [3:0] link_crc(input logic [11:0] ad);
    return crc4({28'h0000000, ad}); // RQ24
  endfunction : link_crc

  // ****************************************
  // pin synchronisers
  // ****************************************
  scl_pkg::scl_pins_t pin_meta;
  scl_pkg::scl_pins_t pin_sync;
  scl_pkg::scl_pins_t pin_prev;

  // idle pin levels, so leaving reset shows no false latch edge
  localparam scl_pkg::scl_pins_t pins_idle = '{
    sclk: 1'b0,
    latch: 1'b1,
    serial_in: 1'b0,
    rst: 1'b0,
    oe_n: 1'b0
  };

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pin_meta <= pins_idle;
      pin_sync <= pins_idle;
      pin_prev <= pins_idle;
    end else begin
      pin_meta <= {SCLK_I, LATCH_I, SERIAL_IN_I, RESET_I, OUTPUTS_ALLOW_LOW_I};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic dev_rst;
  logic sclk_rise;
  logic sclk_fall;
  logic latch_rise;

  assign dev_rst = pin_sync.rst;
  assign sclk_rise = pin_sync.sclk & ~pin_prev.sclk;
  assign sclk_fall = ~pin_sync.sclk & pin_prev.sclk;
  assign latch_rise = pin_sync.latch & ~pin_prev.latch;

  // ****************************************
  // frame capture
  // ****************************************
  scl_pkg::scl_frame_t shift;
  logic [15:0] rd_shift;
  logic out_bit;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      shift <= '0;
    end else if (dev_rst) begin
      shift <= '0; // RQ1
    end else if (!pin_sync.latch && sclk_rise) begin
      shift <= {shift[14:0], pin_sync.serial_in}; // RQ4 RQ9
    end
  end

  // ****************************************
  // frame decode
  // ****************************************
  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] set3;
  logic [7:0] set7;
  logic locked;
  logic por_flag;
  logic crc_err;
  logic [3:0] rd_addr;
  logic load_rd;
  logic [3:0] map_checksum;

  logic crc_en;
  logic crc_ok;
  logic frame_bad;
  logic frame_take;
  logic wr_ok;
  logic map_clear;
  logic cmd_hit;

  assign crc_en = set3[`SCL_BIT_CRC_EN];
  assign crc_ok = (link_crc({shift.addr, shift.data}) == shift.crc);
  assign frame_bad = latch_rise && crc_en && !crc_ok; // RQ5 RQ17
  assign frame_take = latch_rise && !(crc_en && !crc_ok); // RQ16
  assign wr_ok = frame_take && !locked; // RQ25
  assign map_clear = wr_ok && shift.addr == `SCL_ADDR_MAP_CLEAR &&
                     shift.data == `SCL_KEY_MAP_CLEAR; // RQ14
  assign cmd_hit = wr_ok && shift.addr == `SCL_ADDR_COMMAND;

  // settings registers
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      set0 <= `SCL_SET_RESET;
      set1 <= `SCL_SET_RESET;
      set2 <= `SCL_SET_RESET;
      set3 <= `SCL_SET_RESET; // RQ6
      set7 <= `SCL_SET_RESET;
    end else if (dev_rst || map_clear) begin
      set0 <= `SCL_SET_RESET; // RQ1 RQ14
      set1 <= `SCL_SET_RESET;
      set2 <= `SCL_SET_RESET;
      set3 <= `SCL_SET_RESET; // RQ6
      set7 <= `SCL_SET_RESET;
    end else if (wr_ok) begin
      case (shift.addr)
        `SCL_ADDR_SET0: begin
          set0 <= shift.data;
        end
        `SCL_ADDR_SET1: begin
          set1 <= shift.data;
        end
        `SCL_ADDR_SET2: begin
          set2 <= shift.data;
        end
        `SCL_ADDR_SET3: begin
          set3 <= shift.data;
        end
        `SCL_ADDR_SET7: begin
          set7 <= shift.data;
        end
        default: begin
        end
      endcase
    end
  end

  // write lock; key register stays reachable while locked
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      locked <= 1'b0; // RQ10
    end else if (dev_rst || map_clear) begin
      locked <= 1'b0;
    end else if (frame_take && shift.addr == `SCL_ADDR_WP_KEY) begin
      if (shift.data == `SCL_KEY_UNLOCK) begin
        locked <= 1'b0; // RQ11 RQ25
      end else if (shift.data == `SCL_KEY_LOCK) begin
        locked <= 1'b1; // RQ12
      end
    end
  end

  // power-up flag only set by the power-on reset
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      por_flag <= 1'b1; // RQ2
    end else if (cmd_hit && shift.data[`SCL_BIT_CMD_CLR_POR]) begin
      por_flag <= 1'b0; // RQ15
    end
  end

  // link crc error flag, set beats clear
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      crc_err <= 1'b0;
    end else if (dev_rst || map_clear) begin
      crc_err <= 1'b0;
    end else if (frame_bad) begin
      crc_err <= 1'b1; // RQ19
    end else if (cmd_hit && shift.data[`SCL_BIT_CMD_CLR_CRC]) begin
      crc_err <= 1'b0; // RQ19
    end
  end

  // ****************************************
  // map checksum
  // ****************************************
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      map_checksum <= `SCL_CRC_INIT;
    end else begin
      map_checksum <= crc4({set0, set1, set2, set3, set7}); // RQ20 RQ22
    end
  end

  // ****************************************
  // read path
  // ****************************************
  function automatic logic [7:0] read_mux(input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `SCL_ADDR_STATUS: begin
        v[`SCL_BIT_ST_POR] = por_flag;
        v[`SCL_BIT_ST_CRC_ERR] = crc_err;
        v[`SCL_BIT_ST_WP] = locked; // RQ13
      end
      `SCL_ADDR_CHECKSUM: begin
        v = {4'h0, map_checksum}; // RQ20
      end
      `SCL_ADDR_SET0: begin
        v = set0;
      end
      `SCL_ADDR_SET1: begin
        v = set1;
      end
      `SCL_ADDR_SET2: begin
        v = set2;
      end
      `SCL_ADDR_SET3: begin
        v = set3;
      end
      `SCL_ADDR_SET7: begin
        v = set7;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction : read_mux

  // pointer follows any acted-on frame
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rd_addr <= 4'h0;
    end else if (dev_rst) begin
      rd_addr <= 4'h0;
    end else if (frame_take) begin
      rd_addr <= shift.addr; // RQ7
    end
  end

  // load waits a cycle so the read sees the register just written
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      load_rd <= 1'b0;
    end else if (dev_rst) begin
      load_rd <= 1'b0;
    end else begin
      load_rd <= frame_take;
    end
  end

  // the function reads the registers directly; a plain assign would miss them
  logic [7:0] rd_data;
  always_comb begin
    rd_data = read_mux(rd_addr);
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rd_shift <= '0;
    end else if (dev_rst) begin
      rd_shift <= '0;
    end else if (load_rd) begin
      rd_shift <= {rd_addr, rd_data, link_crc({rd_addr, rd_data})};
    end else if (pin_sync.latch && sclk_fall) begin
      rd_shift <= {rd_shift[14:0], 1'b0};
    end
  end

  // one output bit serves both the shift-through and the read-back
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      out_bit <= 1'b0;
    end else if (dev_rst) begin
      out_bit <= 1'b0;
    end else if (pin_sync.latch && sclk_fall) begin
      out_bit <= rd_shift[15]; // RQ8
    end else if (!pin_sync.latch && sclk_rise) begin
      out_bit <= shift[15]; // RQ4
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SERIAL_OUT_O <= 1'b0;
    end else begin
      SERIAL_OUT_O <= out_bit;
    end
  end

  // drive stops one clock after the synchronised reset pin goes high
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SERIAL_OUT_OE_O <= 1'b0;
    end else begin
      SERIAL_OUT_OE_O <= ~dev_rst; // RQ1
    end
  end

  // open-drain data stays low; only the enable ever moves
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      FAULT_ALARM_N_O <= 1'b0;
    end else begin
      FAULT_ALARM_N_O <= 1'b0;
    end
  end

  // crc errors stay off the alarm line; only the force bit pulls it
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      FAULT_ALARM_N_OE_O <= 1'b0;
    end else begin
      FAULT_ALARM_N_OE_O <= set3[`SCL_BIT_FORCE_FAULT]; // RQ18
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CHANNEL_ON_O <= 8'h00;
    end else begin
      CHANNEL_ON_O <= pin_sync.oe_n ? 8'h00 : set0; // RQ3
    end
  end

endmodule : scl_serial_ctrl

`default_nettype wire

// ### scl_serial_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module scl_chk (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic RESET_I,
  input wire logic SCLK_I,
  input wire logic LATCH_I,
  input wire logic SERIAL_IN_I,
  input wire logic OUTPUTS_ALLOW_LOW_I,
  input wire logic SERIAL_OUT_O,
  input wire logic SERIAL_OUT_OE_O,
  input wire logic FAULT_ALARM_N_O,
  input wire logic FAULT_ALARM_N_OE_O,
  input wire logic [7:0] CHANNEL_ON_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ****
  // sequences
  // ****
  // six cycles covers the pin sync plus the output register
  sequence s_rst;
    RESET_I [*6];
  endsequence
  sequence s_run;
    !RESET_I [*6];
  endsequence
  sequence s_link_still;
    ($stable(SCLK_I) && $stable(LATCH_I) && $stable(RESET_I)) [*8];
  endsequence
  sequence s_cfg_still;
    ($stable(LATCH_I) && $stable(OUTPUTS_ALLOW_LOW_I) && $stable(RESET_I)) [*8];
  endsequence
  // ****
  // properties
  // ****
  property p_rst_float;
    s_rst |-> !SERIAL_OUT_OE_O;
  endproperty
  property p_rst_ch;
    s_rst |-> CHANNEL_ON_O == 8'h00;
  endproperty
  property p_rst_fault;
    s_rst |-> !FAULT_ALARM_N_OE_O;
  endproperty
  property p_run_drive;
    s_run |-> SERIAL_OUT_OE_O;
  endproperty
  property p_off_ch;
    OUTPUTS_ALLOW_LOW_I [*6] |-> CHANNEL_ON_O == 8'h00;
  endproperty
  property p_so_quiet;
    s_link_still |-> $stable(SERIAL_OUT_O);
  endproperty
  property p_ch_quiet;
    s_cfg_still |-> $stable(CHANNEL_ON_O);
  endproperty
  property p_fault_low;
    FAULT_ALARM_N_O == 1'b0;
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("serial out driven in reset");
  a_rst_ch: assert property (p_rst_ch) else $error("channels on in reset");
  a_rst_fault: assert property (p_rst_fault) else $error("alarm pulled in reset");
  a_run_drive: assert property (p_run_drive) else $error("serial out floats");
  a_off_ch: assert property (p_off_ch) else $error("channels on while disabled");
  a_so_quiet: assert property (p_so_quiet) else $error("serial out moved unclocked");
  a_ch_quiet: assert property (p_ch_quiet) else $error("channels moved without commit");
  a_fault_low: assert property (p_fault_low) else $error("alarm data not low");
endmodule : scl_chk
bind scl_serial_ctrl scl_chk scl_chk_inst (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .RESET_I(RESET_I), .SCLK_I(SCLK_I),
  .LATCH_I(LATCH_I), .SERIAL_IN_I(SERIAL_IN_I), .OUTPUTS_ALLOW_LOW_I(OUTPUTS_ALLOW_LOW_I),
  .SERIAL_OUT_O(SERIAL_OUT_O), .SERIAL_OUT_OE_O(SERIAL_OUT_OE_O),
  .FAULT_ALARM_N_O(FAULT_ALARM_N_O), .FAULT_ALARM_N_OE_O(FAULT_ALARM_N_OE_O),
  .CHANNEL_ON_O(CHANNEL_ON_O)
);
`default_nettype wire

// ### scl_host.sv
`timescale 1ns/1ps
`default_nettype none
module scl_host (
  input wire logic clk_i,
  input wire logic serial_out_i,
  input wire logic serial_out_oe_i,
  output logic sclk_o,
  output logic latch_o,
  output logic serial_in_o
);
  logic last = 1'b0;
  logic serial_out_w;
  // undriven line shows the inverse, never a stale match
  assign serial_out_w = serial_out_oe_i ? serial_out_i : ~last;
  always @(posedge clk_i) if (serial_out_oe_i) last <= serial_out_i;
  initial begin
    sclk_o = 1'b0;
    latch_o = 1'b1;
    serial_in_o = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask : half
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    latch_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_in_o = w[i];
      half();
      sclk_o = 1'b1;
      half();
      sclk_o = 1'b0;
    end
    half();
    latch_o = 1'b1;
    repeat (12) @(negedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b1;
      half();
      sclk_o = 1'b0;
      half();
      r[i] = serial_out_w;
    end
  endtask : xfer
endmodule : scl_host
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scl_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("FAIL %0t %h %h", $time, a, b); end end
module tb_top;
  logic clk, rst_b, dev_rst, allow_low;
  logic [15:0] r, t;
  wire sclk, latch, serial_in, so, so_oe, fa, fa_oe;
  wire [7:0] ch;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  scl_serial_ctrl scl_serial_ctrl_inst (.CLK_I(clk), .RST_B_I(rst_b), .RESET_I(dev_rst),
    .SCLK_I(sclk), .LATCH_I(latch), .SERIAL_IN_I(serial_in), .OUTPUTS_ALLOW_LOW_I(allow_low),
    .SERIAL_OUT_O(so), .SERIAL_OUT_OE_O(so_oe), .FAULT_ALARM_N_O(fa),
    .FAULT_ALARM_N_OE_O(fa_oe), .CHANNEL_ON_O(ch));
  scl_host scl_host_inst (.clk_i(clk), .serial_out_i(so), .serial_out_oe_i(so_oe),
    .sclk_o(sclk), .latch_o(latch), .serial_in_o(serial_in));
  // ****
  // helpers
  // ****
  function automatic logic [3:0] crc4(input logic [39:0] m, input int n);
    logic [4:0] c;
    c = 5'h00;
    for (int i = n + 3; i >= 0; i--) begin
      c = {c[3:0], (i >= 4) ? m[i - 4] : 1'b0};
      if (c[4]) c = c ^ 5'h13;
    end
    return c[3:0];
  endfunction : crc4
  function automatic logic [15:0] fr(input logic [3:0] a, input logic [7:0] d);
    return {a, d, crc4({28'h0, a, d}, 12)};
  endfunction : fr
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    scl_host_inst.xfer(fr(a, d), t);
  endtask : wr
  task automatic bad(input logic [3:0] a, input logic [7:0] d);
    scl_host_inst.xfer(fr(a, d) ^ 16'h0005, t);
  endtask : bad
  task automatic rd(input logic [3:0] a);
    scl_host_inst.xfer(fr(a, 8'h00), r);
    `CHK(r[15:12], a)
    `CHK(r[3:0], crc4({28'h0, r[15:4]}, 12))
  endtask : rd
  task automatic test_done();
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // ****
  // scenarios
  // ****
  task automatic t_por();
    rd(`SCL_ADDR_STATUS);
    `CHK(r[6:4], 3'b001)
    rd(`SCL_ADDR_CHECKSUM);
    `CHK(r[7:4], 4'h0)
  endtask : t_por
  task automatic t_wr();
    wr(`SCL_ADDR_SET0, 8'hA5);
    `CHK(ch, 8'hA5)
    allow_low = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(ch, 8'h00)
    allow_low = 1'b0;
    repeat (6) @(negedge clk);
    `CHK(ch, 8'hA5)
  endtask : t_wr
  task automatic t_lock();
    wr(`SCL_ADDR_WP_KEY, `SCL_KEY_LOCK);
    rd(`SCL_ADDR_STATUS);
    `CHK(r[6], 1'b1)
    wr(`SCL_ADDR_SET0, 8'h3C);
    `CHK(ch, 8'hA5)
    wr(`SCL_ADDR_WP_KEY, `SCL_KEY_UNLOCK);
    rd(`SCL_ADDR_STATUS);
    `CHK(r[6], 1'b0)
    wr(`SCL_ADDR_SET0, 8'h3C);
    `CHK(ch, 8'h3C)
  endtask : t_lock
  task automatic t_crc();
    bad(`SCL_ADDR_SET0, 8'h5A);
    `CHK(ch, 8'h5A)
    rd(`SCL_ADDR_STATUS);
    `CHK(r[5], 1'b0)
    wr(`SCL_ADDR_SET3, 8'h08);
    bad(`SCL_ADDR_SET0, 8'h66);
    `CHK(ch, 8'h5A)
    `CHK(fa_oe, 1'b0)
    `CHK(fa, 1'b0)
    rd(`SCL_ADDR_STATUS);
    `CHK(r[5], 1'b1)
    wr(`SCL_ADDR_COMMAND, 8'h01);
    rd(`SCL_ADDR_STATUS);
    `CHK(r[5], 1'b0)
  endtask : t_crc
  task automatic t_sum();
    wr(`SCL_ADDR_SET1, 8'h11);
    wr(`SCL_ADDR_SET7, 8'hC3);
    rd(`SCL_ADDR_CHECKSUM);
    `CHK(r[7:4], crc4({8'h5A, 8'h11, 8'h00, 8'h08, 8'hC3}, 40))
  endtask : t_sum
  task automatic t_clr();
    wr(`SCL_ADDR_COMMAND, 8'h02);
    rd(`SCL_ADDR_STATUS);
    `CHK(r[4], 1'b0)
    wr(`SCL_ADDR_MAP_CLEAR, `SCL_KEY_MAP_CLEAR);
    `CHK(ch, 8'h00)
    rd(`SCL_ADDR_CHECKSUM);
    `CHK(r[7:4], 4'h0)
    rd(`SCL_ADDR_STATUS);
    `CHK(r[4], 1'b0)
  endtask : t_clr
  task automatic t_rst();
    wr(`SCL_ADDR_SET3, 8'h08);
    wr(`SCL_ADDR_SET0, 8'h77);
    dev_rst = 1'b1;
    repeat (8) @(negedge clk);
    `CHK(so_oe, 1'b0)
    `CHK(ch, 8'h00)
    dev_rst = 1'b0;
    repeat (8) @(negedge clk);
    bad(`SCL_ADDR_SET0, 8'h12);
    `CHK(ch, 8'h12)
  endtask : t_rst
  // ****
  // main sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    rst_b = 1'b0;
    dev_rst = 1'b0;
    allow_low = 1'b0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_por();
    t_wr();
    t_lock();
    t_crc();
    t_sum();
    t_clr();
    t_rst();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
